// ==== hdl/nfp_consts.svh ====
`ifndef NFP_CONSTS_SVH
`define NFP_CONSTS_SVH
// ************************************************************
// command codes sent on the nand bus
// ************************************************************
`define NFP_CMD_SET_FEAT 8'hef
`define NFP_CMD_GET_FEAT 8'hee
`define NFP_CMD_STATUS 8'h70
`define NFP_CMD_READ 8'h00
`define NFP_CMD_READ_CONF 8'h30
`define NFP_CMD_PROG 8'h80
`define NFP_CMD_PROG_CONF 8'h10
`define NFP_CMD_RAND_IN 8'h85
`define NFP_CMD_RESET 8'hff
// ************************************************************
// feature addresses and values
// ************************************************************
`define NFP_FA_ARRAY_MODE 8'h90
`define NFP_FA_BLOCK_LOCK 8'ha0
`define NFP_AM_NORMAL 8'h00
`define NFP_AM_OTP_ACCESS 8'h01
`define NFP_AM_OTP_LOCK 8'h03
`define NFP_AM_RESET 8'h00
`define NFP_BL_RESET 8'h38
`define NFP_BL_SOLID_BIT 0
`define NFP_ST_PROT_FAIL 8'h60
`define NFP_ST_READY_BIT 6
`define NFP_OTP_FIRST_PAGE 8'h02
`define NFP_OTP_LAST_PAGE 8'h1f
`define NFP_OTP_MAX_PARTIAL 4'h8
// ************************************************************
// controller register offsets (software side)
// ************************************************************
`define NFP_REG_CTRL 4'h0
`define NFP_REG_FADDR 4'h1
`define NFP_REG_PARAM 4'h2
`define NFP_REG_STATUS 4'h3
`define NFP_REG_RDATA 4'h4
`define NFP_REG_DEVSTAT 4'h5
`define NFP_REG_OTPPAGE 4'h6
`define NFP_REG_OTPCNT 4'h7
// ctrl register write codes
`define NFP_OP_SET 3'h1
`define NFP_OP_GET 3'h2
`define NFP_OP_STATUS 3'h3
`define NFP_OP_OTP_LOCK 3'h4
`define NFP_OP_RESET 3'h5
// ************************************************************
// timing, ref_clk at 10 MHz
// ************************************************************
`define NFP_CLK_NS 100
`define NFP_T_WE_NS 100
`define NFP_WE_CYC (((`NFP_T_WE_NS) + (`NFP_CLK_NS) - 1) / (`NFP_CLK_NS))
`define NFP_T_FEAT_NS 1000
`define NFP_FEAT_CYC ((`NFP_T_FEAT_NS) / (`NFP_CLK_NS))
`endif

// ==== hdl/nfp_pkg.sv ====
package nfp_pkg;
  typedef enum logic [2:0] {
    NFP_CYC_CMD,
    NFP_CYC_ADDR,
    NFP_CYC_DIN,
    NFP_CYC_DOUT
  } nfp_cyc_e;
  typedef logic [7:0] nfp_byte_t;
endpackage

// ==== hdl/nfp_cycle.sv ====
`include "nfp_consts.svh"
// one bus cycle on the nand pins: command, address, data in or data out
module nfp_cycle
  import nfp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic start,
  input wire nfp_pkg::nfp_cyc_e kind,
  input wire nfp_pkg::nfp_byte_t wdata,
  input wire nfp_pkg::nfp_byte_t io_in_s,
  output logic done,
  output nfp_pkg::nfp_byte_t rdata,
  output logic cle_r,
  output logic ale_r,
  output logic we_n_r,
  output logic re_n_r,
  output nfp_pkg::nfp_byte_t io_out_r,
  output logic io_oe_r
);
  localparam logic [3:0] PH = 4'(`NFP_WE_CYC);
  logic [3:0] cnt_r;
  logic busy_r;
  logic rd_r;
  // ************************************************************
  // strobe sequencer: strobe low PH cycles, then high PH cycles on writes, two cycles on reads
  // ************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      cnt_r <= 4'h0;
      busy_r <= 1'b0;
      rd_r <= 1'b0;
      cle_r <= 1'b0;
      ale_r <= 1'b0;
      we_n_r <= 1'b1;
      re_n_r <= 1'b1;
      io_out_r <= 8'h00;
      io_oe_r <= 1'b0;
      done <= 1'b0;
      rdata <= 8'h00;
    end else begin
      done <= 1'b0;
      if (!busy_r && start) begin
        busy_r <= 1'b1;
        cnt_r <= 4'h0;
        rd_r <= (kind == NFP_CYC_DOUT);
        cle_r <= (kind == NFP_CYC_CMD);
        ale_r <= (kind == NFP_CYC_ADDR);
        we_n_r <= (kind == NFP_CYC_DOUT);
        re_n_r <= (kind != NFP_CYC_DOUT);
        io_out_r <= wdata;
        io_oe_r <= (kind != NFP_CYC_DOUT);
      end else if (busy_r) begin
        cnt_r <= cnt_r + 4'h1;
        if (cnt_r == PH - 4'h1) begin
          we_n_r <= 1'b1;
          re_n_r <= 1'b1;
        end
        // synced io trails the pin by two edges; the device holds its byte
        if (rd_r && cnt_r == PH + 4'h1) begin
          rdata <= io_in_s;
        end
        if (cnt_r == (rd_r ? PH + 4'h1 : PH + PH - 4'h1)) begin
          busy_r <= 1'b0;
          done <= 1'b1;
          cle_r <= 1'b0;
          ale_r <= 1'b0;
          io_oe_r <= 1'b0;
        end
      end
    end
  end
endmodule

// ==== hdl/nfp_host.sv ====
`include "nfp_consts.svh"
module nfp_host
  import nfp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [3:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  output logic [31:0] sw_rdata_r,
  output logic nand_cle_r,
  output logic nand_ale_r,
  output logic nand_we_n_r,
  output logic nand_re_n_r,
  output logic nand_wp_n_r,
  output nfp_pkg::nfp_byte_t nand_io_out_r,
  output logic nand_io_oe_r,
  input wire nfp_pkg::nfp_byte_t nand_io_in,
  input wire logic nand_rb_n
);
  import nfp_pkg::*;
  typedef enum logic [3:0] {
    NFP_IDLE, NFP_CMD, NFP_ADDR, NFP_DATA, NFP_WAIT, NFP_RESUME, NFP_GETB, NFP_DONE
  } nfp_state_e;
  nfp_state_e state_r;
  nfp_byte_t io_s1_r, io_s2_r, faddr_r, devstat_r, otp_page_r;
  nfp_byte_t am_shadow_r, bl_shadow_r, cy_wdata_r, cy_rdata;
  logic rb_s1_r, rb_s2_r, cy_start_r, cy_done, refuse;
  logic [2:0] op_r;
  logic [31:0] param_r, rdbuf_r;
  logic [2:0] idx_r;
  logic [7:0] wait_r;
  logic err_r, busy_r, done_r, stat_pend_r, otp_locked_r;
  logic [3:0] otp_cnt_r [0:31];
  nfp_cyc_e cy_kind_r;
  logic [7:0] feat_wait;
  assign feat_wait = 8'(`NFP_FEAT_CYC);
  // ************************************************************
  // pin synchronisers
  // ************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      io_s1_r <= 8'h00;
      io_s2_r <= 8'h00;
      rb_s1_r <= 1'b0;
      rb_s2_r <= 1'b0;
    end else begin
      io_s1_r <= nand_io_in;
      io_s2_r <= io_s1_r;
      rb_s1_r <= nand_rb_n;
      rb_s2_r <= rb_s1_r;
    end
  end
  // ************************************************************
  // pin cycle engine
  // ************************************************************
  nfp_cycle u_cycle (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .start(cy_start_r),
    .kind(cy_kind_r),
    .wdata(cy_wdata_r),
    .io_in_s(io_s2_r),
    .done(cy_done),
    .rdata(cy_rdata),
    .cle_r(nand_cle_r),
    .ale_r(nand_ale_r),
    .we_n_r(nand_we_n_r),
    .re_n_r(nand_re_n_r),
    .io_out_r(nand_io_out_r),
    .io_oe_r(nand_io_oe_r)
  );
  // ************************************************************
  // refusal check for a requested set or lock operation
  // ************************************************************
  always_comb begin
    refuse = 1'b0;
    if (op_r == `NFP_OP_SET) begin
      if (faddr_r != `NFP_FA_ARRAY_MODE && faddr_r != `NFP_FA_BLOCK_LOCK) begin
        refuse = 1'b1; // reserved address, nothing sent
      end
      if (faddr_r == `NFP_FA_BLOCK_LOCK && bl_shadow_r[`NFP_BL_SOLID_BIT]) begin
        refuse = 1'b1; // solid lock freezes bits
      end
      if (faddr_r == `NFP_FA_ARRAY_MODE && otp_locked_r
          && param_r[7:0] != `NFP_AM_NORMAL && param_r[7:0] != `NFP_AM_OTP_ACCESS) begin
        refuse = 1'b1; // lock is permanent
      end
    end
    if (op_r == `NFP_OP_OTP_LOCK && otp_locked_r) begin
      refuse = 1'b1;
    end
  end
  // ************************************************************
  // sequencer: issues command, address and data cycles
  // ************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_r <= NFP_IDLE;
      cy_start_r <= 1'b0;
      cy_kind_r <= NFP_CYC_CMD;
      cy_wdata_r <= 8'h00;
      idx_r <= 3'h0;
      wait_r <= 8'h00;
      busy_r <= 1'b0;
      done_r <= 1'b0;
      err_r <= 1'b0;
      rdbuf_r <= 32'h0000_0000;
      devstat_r <= 8'h00;
      stat_pend_r <= 1'b0;
      am_shadow_r <= `NFP_AM_RESET;
      bl_shadow_r <= `NFP_BL_RESET;
      otp_locked_r <= 1'b0;
      nand_wp_n_r <= 1'b0;
    end else begin
      cy_start_r <= 1'b0;
      case (state_r)
        NFP_IDLE: begin
          if (sw_wr && sw_addr == `NFP_REG_CTRL && sw_wdata[2:0] != 3'h0) begin
            busy_r <= 1'b1;
            done_r <= 1'b0;
            err_r <= 1'b0;
            state_r <= NFP_CMD;
          end
        end
        NFP_CMD: begin
          if (refuse) begin
            err_r <= 1'b1;
            state_r <= NFP_DONE;
          end else begin
            nand_wp_n_r <= (op_r == `NFP_OP_SET || op_r == `NFP_OP_OTP_LOCK);
            cy_start_r <= 1'b1;
            cy_kind_r <= NFP_CYC_CMD;
            idx_r <= 3'h0;
            case (op_r) // plain feature, status, program and reset codes only, no cache read
              `NFP_OP_SET: cy_wdata_r <= `NFP_CMD_SET_FEAT;
              `NFP_OP_GET: cy_wdata_r <= `NFP_CMD_GET_FEAT;
              `NFP_OP_STATUS: cy_wdata_r <= `NFP_CMD_STATUS;
              `NFP_OP_OTP_LOCK: cy_wdata_r <= `NFP_CMD_PROG;
              default: cy_wdata_r <= `NFP_CMD_RESET; // features survive
            endcase
            state_r <= NFP_ADDR;
          end
        end
        NFP_ADDR: begin
          if (cy_done) begin
            if (op_r == `NFP_OP_RESET) begin
              state_r <= NFP_WAIT;
              wait_r <= feat_wait;
            end else if (op_r == `NFP_OP_STATUS) begin
              stat_pend_r <= 1'b1; // data out now shows status
              state_r <= NFP_GETB;
              cy_start_r <= 1'b1;
              cy_kind_r <= NFP_CYC_DOUT;
            end else begin
              cy_start_r <= 1'b1;
              cy_kind_r <= NFP_CYC_ADDR;
              cy_wdata_r <= (op_r == `NFP_OP_OTP_LOCK) ? 8'h00 : faddr_r;
              state_r <= (op_r == `NFP_OP_GET) ? NFP_WAIT : NFP_DATA;
              wait_r <= feat_wait;
            end
          end
        end
        NFP_DATA: begin
          if (cy_done) begin
            cy_start_r <= 1'b1;
            if (op_r == `NFP_OP_OTP_LOCK || idx_r == 3'h4) begin
              if (op_r == `NFP_OP_OTP_LOCK && idx_r == 3'h0) begin
                cy_kind_r <= NFP_CYC_CMD;
                cy_wdata_r <= `NFP_CMD_PROG_CONF; // confirm
                idx_r <= 3'h5;
              end else begin
                cy_start_r <= 1'b0;
                wait_r <= feat_wait;
                state_r <= NFP_WAIT;
              end
            end else begin
              cy_kind_r <= NFP_CYC_DIN;
              cy_wdata_r <= param_r[8*idx_r[1:0] +: 8]; // p1 first
              idx_r <= idx_r + 3'h1;
            end
          end
        end
        NFP_WAIT: begin
          // least wait covers feature busy, then ready/busy high
          if (wait_r != 8'h00) begin
            wait_r <= wait_r - 8'h01;
          end else if (rb_s2_r) begin
            idx_r <= 3'h0;
            if (op_r == `NFP_OP_GET) begin
              cy_start_r <= 1'b1;
              cy_kind_r <= NFP_CYC_DOUT;
              state_r <= NFP_GETB;
            end else begin
              if (op_r == `NFP_OP_SET && faddr_r == `NFP_FA_ARRAY_MODE) begin
                am_shadow_r <= param_r[7:0];
              end
              if (op_r == `NFP_OP_SET && faddr_r == `NFP_FA_BLOCK_LOCK) begin
                bl_shadow_r <= {2'b00, param_r[5:0]}; // strap high assumed
              end
              if (op_r == `NFP_OP_OTP_LOCK) begin
                otp_locked_r <= 1'b1;
              end
              state_r <= NFP_DONE;
            end
          end
        end
        NFP_RESUME: begin
          if (cy_done) begin
            stat_pend_r <= 1'b0;
            cy_start_r <= 1'b1;
            cy_kind_r <= NFP_CYC_DOUT;
            state_r <= NFP_GETB;
          end
        end
        NFP_GETB: begin
          if (cy_done) begin
            if (op_r == `NFP_OP_STATUS) begin
              devstat_r <= cy_rdata; // 60h reports protected block
              state_r <= NFP_DONE;
            end else begin
              rdbuf_r[8*idx_r[1:0] +: 8] <= cy_rdata;
              idx_r <= idx_r + 3'h1;
              if (idx_r == 3'h3) begin
                state_r <= NFP_DONE;
              end else begin
                cy_start_r <= 1'b1;
              end
            end
          end
        end
        default: begin
          nand_wp_n_r <= 1'b0; // protect again once the op ends
          busy_r <= 1'b0;
          done_r <= 1'b1;
          state_r <= NFP_IDLE;
        end
      endcase
      // a get resumed after a status read sends read command first
      if (state_r == NFP_IDLE && sw_wr && sw_addr == `NFP_REG_CTRL
          && sw_wdata[2:0] == `NFP_OP_GET && sw_wdata[3] && stat_pend_r) begin
        cy_start_r <= 1'b1;
        cy_kind_r <= NFP_CYC_CMD;
        cy_wdata_r <= `NFP_CMD_READ;
        idx_r <= 3'h0;
        state_r <= NFP_RESUME;
      end
    end
  end
  // ************************************************************
  // software registers: operation, address, parameters, otp count
  // ************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      op_r <= 3'h0;
      faddr_r <= 8'h00;
      param_r <= 32'h0000_0000;
      otp_page_r <= `NFP_OTP_FIRST_PAGE;
      for (int i = 0; i < 32; i++) begin
        otp_cnt_r[i] <= 4'h0;
      end
    end else begin
      if (sw_wr && state_r == NFP_IDLE) begin
        if (sw_addr == `NFP_REG_CTRL) begin
          op_r <= sw_wdata[2:0];
        end else if (sw_addr == `NFP_REG_FADDR) begin
          faddr_r <= sw_wdata[7:0];
        end else if (sw_addr == `NFP_REG_PARAM) begin
          param_r <= sw_wdata;
        end else if (sw_addr == `NFP_REG_OTPPAGE) begin
          // only pages 02h..1Fh form the otp area
          if (sw_wdata[7:0] >= `NFP_OTP_FIRST_PAGE && sw_wdata[7:0] <= `NFP_OTP_LAST_PAGE) begin
            otp_page_r <= sw_wdata[7:0];
          end
        end else if (sw_addr == `NFP_REG_OTPCNT) begin
          // software books a partial program; capped at eight
          if (!otp_locked_r && otp_cnt_r[otp_page_r[4:0]] != `NFP_OTP_MAX_PARTIAL) begin
            otp_cnt_r[otp_page_r[4:0]] <= otp_cnt_r[otp_page_r[4:0]] + 4'h1;
          end
        end
      end
    end
  end
  // ************************************************************
  // read port: data in the cycle after the strobe
  // ************************************************************
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      sw_rdata_r <= 32'h0000_0000;
    end else if (sw_rd) begin
      if (sw_addr == `NFP_REG_CTRL) begin
        sw_rdata_r <= {29'h0, op_r};
      end else if (sw_addr == `NFP_REG_FADDR) begin
        sw_rdata_r <= {24'h0, faddr_r};
      end else if (sw_addr == `NFP_REG_PARAM) begin
        sw_rdata_r <= param_r;
      end else if (sw_addr == `NFP_REG_STATUS) begin
        sw_rdata_r <= {12'h0, 1'b0, otp_locked_r, stat_pend_r, rb_s2_r,
                       am_shadow_r, 1'b0, err_r, done_r, busy_r, 4'h0};
      end else if (sw_addr == `NFP_REG_RDATA) begin
        sw_rdata_r <= rdbuf_r;
      end else if (sw_addr == `NFP_REG_DEVSTAT) begin
        sw_rdata_r <= {16'h0, bl_shadow_r, devstat_r};
      end else if (sw_addr == `NFP_REG_OTPPAGE) begin
        sw_rdata_r <= {24'h0, otp_page_r};
      end else if (sw_addr == `NFP_REG_OTPCNT) begin
        sw_rdata_r <= {28'h0, otp_cnt_r[otp_page_r[4:0]]};
      end else begin
        sw_rdata_r <= 32'h0000_0000;
      end
    end
  end
endmodule

// ==== sim/nfp_dev_model.sv ====
`include "nfp_consts.svh"
// behavioural flash device on the far side of the host pins
module nfp_dev_model
  import nfp_pkg::*;
(
  input wire logic cle,
  input wire logic ale,
  input wire logic we_n,
  input wire logic re_n,
  input wire logic wp_n,
  input wire nfp_pkg::nfp_byte_t io_h,
  input wire logic io_oe,
  input wire logic protect_strap_pin,
  input wire logic slow,
  output nfp_pkg::nfp_byte_t io_d,
  output logic rb_n
);
  timeunit 1ns;
  timeprecision 1ns;
  localparam nfp_byte_t READY_STAT = 8'he0;
  nfp_byte_t cmd, fa, dout, am, bl;
  nfp_byte_t p[4];
  logic drv, st_sel;
  int n, k;
  // wire level: host byte, held device byte, or a flipped stale value
  assign io_d = io_oe ? io_h : (drv ? dout : ~dout);
  // power-on feature values
  initial begin
    am = `NFP_AM_RESET;
    bl = `NFP_BL_RESET;
    {cmd, fa, dout, drv, st_sel, n, k} = '0;
    rb_n = 1'b1;
  end
  // busy window, short or long as the bench asks
  task automatic busy();
    fork begin
      rb_n = 1'b0;
      #(slow ? 900 : 200);
      rb_n = 1'b1;
    end join_none
  endtask
  // command, address and data latch on the rising write strobe
  always @(posedge we_n) begin
    drv = 1'b0;
    if (cle) begin
      cmd = io_h;
      st_sel = (io_h == `NFP_CMD_STATUS);
      if (io_h == `NFP_CMD_RESET) busy();
    end else if (ale) begin
      fa = io_h;
      n = 0;
      k = 0;
      if (cmd == `NFP_CMD_GET_FEAT) begin
        p = '{default: 8'h00};
        if (fa == `NFP_FA_ARRAY_MODE) p[0] = am;
        if (fa == `NFP_FA_BLOCK_LOCK && protect_strap_pin) p[0] = bl;
        busy();
      end
    end else if (cmd == `NFP_CMD_SET_FEAT && n < 4) begin
      p[n] = io_h;
      n++;
      if (n == 4) begin
        if (fa == `NFP_FA_ARRAY_MODE) am = p[0];
        if (fa == `NFP_FA_BLOCK_LOCK && protect_strap_pin && !bl[0]) bl = p[0];
        busy();
      end
    end
  end
  // each falling read strobe presents the next parameter byte, or the same status byte after 70h, and holds it
  always @(negedge re_n) begin
    dout = st_sel ? READY_STAT : p[k[1:0]];
    drv = 1'b1;
    if (!st_sel) k++;
  end
endmodule

// ==== sim/nfp_host_assertions.sv ====
`include "nfp_consts.svh"
// protocol watch on the host pins and register port
module nfp_host_assertions
  import nfp_pkg::*;
(
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic [3:0] sw_addr,
  input wire logic [31:0] sw_wdata,
  input wire logic sw_wr,
  input wire logic sw_rd,
  input wire logic [31:0] sw_rdata_r,
  input wire logic nand_cle_r,
  input wire logic nand_ale_r,
  input wire logic nand_we_n_r,
  input wire logic nand_re_n_r,
  input wire logic nand_wp_n_r,
  input wire nfp_pkg::nfp_byte_t nand_io_out_r,
  input wire logic nand_io_oe_r,
  input wire nfp_pkg::nfp_byte_t nand_io_in,
  input wire logic nand_rb_n
);
  timeunit 1ns;
  timeprecision 1ns;
  nfp_byte_t fa_r;
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  // feature address last written by software
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) fa_r <= 8'h00;
    else if (sw_wr && sw_addr == `NFP_REG_FADDR) fa_r <= sw_wdata[7:0];
  end
  sequence cmd_s(logic [7:0] c);
    !nand_we_n_r && nand_cle_r && nand_io_out_r == c;
  endsequence
  sequence req_s(logic [2:0] c);
    sw_wr && sw_addr == `NFP_REG_CTRL && sw_wdata[3:0] == {1'b0, c};
  endsequence
  sequence addr_s;
    !nand_we_n_r && nand_ale_r && nand_io_out_r == fa_r;
  endsequence
  // ************************************************************
  // pin timing and ordering
  // ************************************************************
  we_pulse_a: assert property ($fell(nand_we_n_r) |=> nand_we_n_r)
    else $error("write strobe low too long");
  re_pulse_a: assert property ($fell(nand_re_n_r) |=> nand_re_n_r)
    else $error("read strobe low too long");
  strobe_excl_a: assert property (!nand_we_n_r |-> nand_re_n_r && nand_io_oe_r)
    else $error("write cycle without bus drive");
  latch_excl_a: assert property (nand_cle_r |-> !nand_ale_r)
    else $error("command and address latch together");
  read_release_a: assert property (!nand_re_n_r |-> !nand_io_oe_r)
    else $error("host drives bus during read");
  set_start_a: assert property (req_s(`NFP_OP_SET) ##0 fa_r == `NFP_FA_ARRAY_MODE |->
    ##[1:20] cmd_s(`NFP_CMD_SET_FEAT)) else $error("set command not sent");
  set_addr_a: assert property (cmd_s(`NFP_CMD_SET_FEAT) |-> ##[1:8] addr_s)
    else $error("set address missing");
  get_addr_a: assert property (cmd_s(`NFP_CMD_GET_FEAT) |-> ##[1:8] addr_s)
    else $error("get address missing");
  wp_set_a: assert property (cmd_s(`NFP_CMD_SET_FEAT) |-> nand_wp_n_r)
    else $error("write protect low at set");
  status_start_a: assert property (req_s(`NFP_OP_STATUS) |->
    ##[1:20] cmd_s(`NFP_CMD_STATUS)) else $error("status command not sent");
  reset_start_a: assert property (req_s(`NFP_OP_RESET) |->
    ##[1:20] cmd_s(`NFP_CMD_RESET)) else $error("reset command not sent");
  otp_addr_a: assert property (cmd_s(`NFP_CMD_PROG) |->
    ##[1:8] (!nand_we_n_r && nand_ale_r && nand_io_out_r == 8'h00))
    else $error("lock address missing");
  rdata_hold_a: assert property (!sw_rd |=> $stable(sw_rdata_r))
    else $error("read data changed without read");
endmodule
bind nfp_host nfp_host_assertions chk (.ref_clk(ref_clk), .resetn(resetn), .sw_addr(sw_addr),
  .sw_wdata(sw_wdata), .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata_r(sw_rdata_r),
  .nand_cle_r(nand_cle_r), .nand_ale_r(nand_ale_r), .nand_we_n_r(nand_we_n_r),
  .nand_re_n_r(nand_re_n_r), .nand_wp_n_r(nand_wp_n_r), .nand_io_out_r(nand_io_out_r),
  .nand_io_oe_r(nand_io_oe_r), .nand_io_in(nand_io_in), .nand_rb_n(nand_rb_n));

// ==== sim/test_nfp_host.sv ====
`include "nfp_consts.svh"
// self-checking bench for the feature-access host
module test_nfp_host;
  timeunit 1ns;
  timeprecision 1ns;
  import nfp_pkg::*;
  logic ref_clk = 1'b0;
  logic resetn = 1'b0;
  logic sw_wr = 1'b0;
  logic sw_rd = 1'b0;
  logic slow = 1'b0;
  logic rd_d = 1'b0;
  logic [3:0] sw_addr = 4'h0;
  logic [31:0] sw_wdata = 32'h0000_0000;
  logic [31:0] sw_rdata_r, bl_v;
  logic [63:0] note;
  logic cle, ale, we_n, re_n, wp_n, io_oe, rb_n;
  nfp_byte_t io_h, io_d;
  nfp_byte_t modes[3] = '{`NFP_AM_OTP_ACCESS, `NFP_AM_OTP_LOCK, `NFP_AM_NORMAL};
  logic [63:0] exp_q[$];
  int n_errors = 0;
  int check_count = 0;
  always #50 ref_clk = ~ref_clk;
  nfp_host dut (.ref_clk(ref_clk), .resetn(resetn), .sw_addr(sw_addr), .sw_wdata(sw_wdata),
    .sw_wr(sw_wr), .sw_rd(sw_rd), .sw_rdata_r(sw_rdata_r), .nand_cle_r(cle), .nand_ale_r(ale),
    .nand_we_n_r(we_n), .nand_re_n_r(re_n), .nand_wp_n_r(wp_n), .nand_io_out_r(io_h),
    .nand_io_oe_r(io_oe), .nand_io_in(io_d), .nand_rb_n(rb_n));
  nfp_dev_model flash (.cle(cle), .ale(ale), .we_n(we_n), .re_n(re_n), .wp_n(wp_n),
    .io_h(io_h), .io_oe(io_oe), .protect_strap_pin(1'b1), .slow(slow), .io_d(io_d), .rb_n(rb_n));
  // verdict and end of run
  task automatic results();
    if (n_errors == 0 && check_count > 0) $display("[ PASS ]");
    else $display("[ FAIL ]");
    $finish;
  endtask
  // one register port cycle
  task automatic bus(logic w, logic r, logic [3:0] a, logic [31:0] d);
    @(posedge ref_clk);
    sw_wr <= w;
    sw_rd <= r;
    sw_addr <= a;
    sw_wdata <= d;
  endtask
  // note the expected word and mask, then read
  task automatic rd(logic [3:0] a, logic [31:0] e, logic [31:0] m);
    exp_q.push_back({m, e});
    bus(1'b0, 1'b1, a, 32'h0000_0000);
  endtask
  // poll status until busy clears
  task automatic idle();
    for (int t = 0; t < 300; t++) begin
      rd(`NFP_REG_STATUS, 32'h0000_0000, 32'h0000_0000);
      bus(1'b0, 1'b0, 4'h0, 32'h0000_0000);
      @(negedge ref_clk);
      if (sw_rdata_r[4] === 1'b0) return;
    end
    n_errors++;
    $display("[FAIL] %0t busy never cleared", $time);
  endtask
  // address, parameters, op code, then wait
  task automatic op(logic [7:0] fa, logic [31:0] prm, logic [3:0] code);
    slow <= 1'($urandom_range(0, 1));
    bus(1'b1, 1'b0, `NFP_REG_FADDR, {24'h0, fa});
    bus(1'b1, 1'b0, `NFP_REG_PARAM, prm);
    bus(1'b1, 1'b0, `NFP_REG_CTRL, {28'h0, code});
    idle();
  endtask
  // fetch a feature and expect its parameter word
  task automatic get_chk(logic [7:0] fa, logic [31:0] e);
    op(fa, 32'h0000_0000, {1'b0, `NFP_OP_GET});
    rd(`NFP_REG_RDATA, e, 32'hffff_ffff);
  endtask
  always @(posedge ref_clk) rd_d <= sw_rd;
  // compare each read answer against the oldest note
  always @(negedge ref_clk) begin
    if (rd_d && exp_q.size() > 0) begin
      note = exp_q.pop_front();
      if (note[63:32] !== 32'h0000_0000) begin
        check_count++;
        if ((sw_rdata_r & note[63:32]) !== note[31:0]) begin
          n_errors++;
          $display("[FAIL] %0t read %h expected %h", $time, sw_rdata_r, note[31:0]);
        end
      end
    end
  end
  // ************************************************************
  // scenarios
  // ************************************************************
  initial begin
    void'($urandom(32'h8de635bf));
    repeat (20) @(posedge ref_clk);
    resetn <= 1'b1;
    rd(`NFP_REG_STATUS, 32'h0000_0000, 32'h0000_ff10);
    rd(`NFP_REG_DEVSTAT, 32'h0000_3800, 32'h0000_ff00);
    rd(4'hc, 32'h0000_0000, 32'hffff_ffff);
    get_chk(`NFP_FA_ARRAY_MODE, 32'h0000_0000);
    get_chk(`NFP_FA_BLOCK_LOCK, 32'h0000_0038);
    foreach (modes[j]) begin
      op(`NFP_FA_ARRAY_MODE, {24'h0, modes[j]}, {1'b0, `NFP_OP_SET});
      get_chk(`NFP_FA_ARRAY_MODE, {24'h0, modes[j]});
      rd(`NFP_REG_STATUS, {16'h0, modes[j], 8'h0}, 32'h0000_ff10);
    end
    op(8'($urandom_range(0, 143)), 32'h0000_0001, {1'b0, `NFP_OP_SET});
    rd(`NFP_REG_STATUS, 32'h0000_0040, 32'h0000_0040);
    get_chk(`NFP_FA_ARRAY_MODE, 32'h0000_0000);
    bl_v = {26'h0, 3'($urandom_range(0, 7)), 2'($urandom_range(0, 3)), 1'b0};
    op(`NFP_FA_BLOCK_LOCK, bl_v, {1'b0, `NFP_OP_SET});
    get_chk(`NFP_FA_BLOCK_LOCK, bl_v);
    bl_v[0] = 1'b1;
    op(`NFP_FA_BLOCK_LOCK, bl_v, {1'b0, `NFP_OP_SET});
    op(`NFP_FA_BLOCK_LOCK, 32'h0000_0000, {1'b0, `NFP_OP_SET});
    rd(`NFP_REG_STATUS, 32'h0000_0040, 32'h0000_0040);
    rd(`NFP_REG_DEVSTAT, {16'h0, bl_v[7:0], 8'h0}, 32'h0000_ff00);
    get_chk(`NFP_FA_BLOCK_LOCK, bl_v);
    op(`NFP_FA_ARRAY_MODE, {24'h0, `NFP_AM_OTP_ACCESS}, {1'b0, `NFP_OP_SET});
    op(8'h00, 32'h0000_0000, {1'b0, `NFP_OP_RESET});
    get_chk(`NFP_FA_ARRAY_MODE, 32'h0000_0001);
    op(8'h00, 32'h0000_0000, {1'b0, `NFP_OP_STATUS});
    rd(`NFP_REG_DEVSTAT, 32'h0000_00e0, 32'h0000_00ff);
    op(`NFP_FA_ARRAY_MODE, 32'h0000_0000, {1'b1, `NFP_OP_GET});
    rd(`NFP_REG_RDATA, 32'h0000_0001, 32'hffff_ffff);
    get_chk(8'($urandom_range(161, 255)), 32'h0000_0000);
    bus(1'b1, 1'b0, `NFP_REG_OTPPAGE, 32'h0000_0005);
    bus(1'b1, 1'b0, `NFP_REG_OTPPAGE, 32'h0000_0020);
    repeat (9) bus(1'b1, 1'b0, `NFP_REG_OTPCNT, 32'h0000_0000);
    rd(`NFP_REG_OTPPAGE, 32'h0000_0005, 32'h0000_00ff);
    rd(`NFP_REG_OTPCNT, 32'h0000_0008, 32'h0000_000f);
    op(`NFP_FA_ARRAY_MODE, {24'h0, `NFP_AM_OTP_LOCK}, {1'b0, `NFP_OP_SET});
    op(8'h00, 32'h0000_0000, {1'b0, `NFP_OP_OTP_LOCK});
    rd(`NFP_REG_STATUS, 32'h0004_0000, 32'h0004_0040);
    op(8'h00, 32'h0000_0000, {1'b0, `NFP_OP_OTP_LOCK});
    rd(`NFP_REG_STATUS, 32'h0004_0040, 32'h0004_0040);
    op(`NFP_FA_ARRAY_MODE, 32'h0000_0000, {1'b0, `NFP_OP_SET});
    rd(`NFP_REG_STATUS, 32'h0004_0000, 32'h0004_ff50);
    bus(1'b1, 1'b0, `NFP_REG_OTPPAGE, 32'h0000_0007);
    bus(1'b1, 1'b0, `NFP_REG_OTPCNT, 32'h0000_0000);
    rd(`NFP_REG_OTPCNT, 32'h0000_0000, 32'h0000_000f);
    bus(1'b0, 1'b0, 4'h0, 32'h0000_0000);
    repeat (4) @(posedge ref_clk);
    results();
  end
  // hang guard, well past the expected run length
  initial begin
    #(100 * 40000);
    n_errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    results();
  end
endmodule
